/* File: logic/awdu_unit.sv */
// aux pin configuration, grouped interrupt routing and watchdog timer behind an APB slave
// assumes APB inputs synchronous to clock; pad inputs already synchronous; one clock domain
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "awdu_params.svh"
module awdu_unit #(
  parameter int unsigned CYCLES_PER_SEC  = `AWDU_SEC_NS / `AWDU_CLK_NS,
  parameter int unsigned SEC_PER_MIN     = `AWDU_SEC_PER_MIN,
  parameter int unsigned DEBOUNCE_CYCLES = (`AWDU_DEBOUNCE_NS + `AWDU_CLK_NS - 1) / `AWDU_CLK_NS
)(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        padIn,
  output logic [1:0]             padOut,
  output logic [1:0]             padOe,
  input  wire logic [1:0]        parallelDataLine,
  input  wire logic [1:0]        pinIrqLine,
  input  wire logic              groupOneIn,
  input  wire logic              gamePortAccess,
  input  wire logic              keyboardIrq,
  input  wire logic              mouseIrq,
  input  wire logic              powerLedIn,
  output logic                   powerIndicatorOutput,
  output logic                   timeoutStatus,
  output logic [15:0]            irqOut
);
  import awdu_pkg::*;

  localparam int PW = $clog2(CYCLES_PER_SEC);
  localparam int MW = $clog2(SEC_PER_MIN + 1);
  localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);

  // refuse counts the counters cannot hold
  if (CYCLES_PER_SEC < 2 || SEC_PER_MIN < 1 || DEBOUNCE_CYCLES < 1)
  begin : g_bad
    $error("awdu_unit: counts out of range");
  end

  awdu_byte_t    pinCfg_q [2];
  awdu_byte_t    grpCtl_q [2];
  logic          unitSec_q;
  awdu_byte_t    toVal_q;
  awdu_byte_t    reloadCfg_q;
  logic          status_q;
  logic          activate_q;
  logic [1:0]    pinData_q;
  logic [31:0]   prdata_q;
  logic [PW-1:0] presc_q;
  logic [MW-1:0] minCnt_q;
  awdu_byte_t    count_q;
  awdu_byte_t    count_d;
  logic          kbdPrev_q;
  logic          mousePrev_q;
  logic [1:0]    filt_q;
  logic [DW-1:0] deb_q [2];

  // bus decode; only an index with the upper bits clear can hit
  wire [9:0] idx      = paddr[11:2];
  wire       low      = (idx[9:8] == 2'h0);
  wire       hitPinA  = low && idx[7:0] == `AWDU_IDX_PIN_A;
  wire       hitPinB  = low && idx[7:0] == `AWDU_IDX_PIN_B;
  wire       hitGrp2  = low && idx[7:0] == `AWDU_IDX_GRP_TWO;
  wire       hitGrp1  = low && idx[7:0] == `AWDU_IDX_GRP_ONE;
  wire       hitUnit  = low && idx[7:0] == `AWDU_IDX_UNIT;
  wire       hitVal   = low && idx[7:0] == `AWDU_IDX_VALUE;
  wire       hitCfg   = low && idx[7:0] == `AWDU_IDX_RELOAD;
  wire       hitStat  = low && idx[7:0] == `AWDU_IDX_STATUS;
  wire       hitData  = low && idx[7:0] == `AWDU_IDX_PIN_DATA;
  wire       hitAct   = low && idx[7:0] == `AWDU_IDX_ACTIVATE;
  wire       mapped   = hitPinA | hitPinB | hitGrp2 | hitGrp1 | hitUnit | hitVal | hitCfg | hitStat | hitData | hitAct;
  wire       setup    = psel & ~penable;
  wire       wrEn     = psel & penable & pwrite & mapped;
  wire [7:0] wb       = pwdata[7:0];
  wire       wrVal    = wrEn & hitVal;
  wire       wrStat   = wrEn & hitStat;
  wire       forceWr  = wrStat & wb[`AWDU_B_FORCE];

  // answer in the access cycle: data captured at setup so prdata comes from a flop
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  wire [1:0] pinVal;
  wire [7:0] rdByte = hitPinA ? pinCfg_q[0]
                    : hitPinB ? pinCfg_q[1]
                    : hitGrp2 ? grpCtl_q[1]
                    : hitGrp1 ? grpCtl_q[0]
                    : hitUnit ? {unitSec_q, 7'h00}
                    : hitVal  ? toVal_q
                    : hitCfg  ? reloadCfg_q
                    : hitStat ? {7'h00, status_q}
                    : hitData ? {2'h0, pinVal, 2'h0, pinData_q}
                    : hitAct  ? {7'h00, activate_q}
                    : 8'h00;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      prdata_q <= 32'h0;
    else if (setup)
      prdata_q <= {24'h0, rdByte};
  end

  // pin and group registers; reserved bits never store
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pinCfg_q[0] <= `AWDU_PIN_RESET;
      pinCfg_q[1] <= `AWDU_PIN_RESET;
      grpCtl_q[0] <= `AWDU_ZERO_RESET;
      grpCtl_q[1] <= `AWDU_ZERO_RESET;
      pinData_q   <= 2'h0;
      activate_q  <= 1'b0;
    end
    else
    begin
      if (wrEn && hitPinA) pinCfg_q[0] <= wb & `AWDU_PIN_MASK;
      if (wrEn && hitPinB) pinCfg_q[1] <= wb & `AWDU_PIN_MASK;
      if (wrEn && hitGrp1) grpCtl_q[0] <= wb & `AWDU_GRP_MASK;
      if (wrEn && hitGrp2) grpCtl_q[1] <= wb & `AWDU_GRP_MASK;
      if (wrEn && hitData) pinData_q <= wb[1:0];
      if (wrEn && hitAct) activate_q <= wb[0];
    end
  end

  // watchdog registers clear on reset; unit low bits are dropped so they can never steer anything
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      unitSec_q   <= 1'b0;
      toVal_q     <= `AWDU_ZERO_RESET;
      reloadCfg_q <= `AWDU_ZERO_RESET;
    end
    else
    begin
      if (wrEn && hitUnit) unitSec_q <= wb[`AWDU_B_SECONDS];
      if (wrVal) toVal_q <= wb;
      if (wrEn && hitCfg) reloadCfg_q <= wb;
    end
  end

  // per pin: logical value, function source and driver type
  wire [1:0] isIn;
  wire [1:0] pinSrc;
  wire [1:0] drvLvl;
  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    wire        dirIn = pinCfg_q[i][`AWDU_B_DIR];
    wire        pol   = pinCfg_q[i][`AWDU_B_POL];
    wire        drain = pinCfg_q[i][`AWDU_B_DRAIN];
    awdu_func_e fn;
    assign fn        = awdu_func_e'(pinCfg_q[i][4:3]);
    assign isIn[i]   = dirIn;
    assign pinVal[i] = padIn[i] ^ pol;
    // data line, irq line or register bit; reserved code drives nothing
    assign pinSrc[i] = (fn == AWDU_FN_DATA) ? parallelDataLine[i]
                     : (fn == AWDU_FN_IRQ)  ? pinIrqLine[i]
                     : pinData_q[i];
    assign drvLvl[i] = pinSrc[i] ^ pol;
    wire drive = ~dirIn & (fn != AWDU_FN_RSVD);
    // open drain only ever pulls low, so a high level lets the board pull-up win
    assign padOut[i] = drain ? 1'b0 : drvLvl[i];
    assign padOe[i]  = drive & (drain ? ~drvLvl[i] : 1'b1);
  end

  // group two gathers member input pins; group one comes from pins outside this block
  wire [1:0] grpRaw = {|(pinVal & isIn & {pinCfg_q[1][`AWDU_B_MEMBER], pinCfg_q[0][`AWDU_B_MEMBER]}),
                       groupOneIn};
  wire [1:0] grpSig;
  wire [15:0] routeHit [3];
  for (genvar g = 0; g < 2; g++)
  begin : g_grp
    wire stable = (deb_q[g] == DW'(DEBOUNCE_CYCLES - 1));
    // filter follows the raw level only once it held for the debounce time
    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
      begin
        filt_q[g] <= 1'b0;
        deb_q[g]  <= '0;
      end
      else if (grpRaw[g] == filt_q[g])
        deb_q[g] <= '0;
      else if (stable)
      begin
        filt_q[g] <= grpRaw[g];
        deb_q[g]  <= '0;
      end
      else
        deb_q[g] <= deb_q[g] + DW'(1);
    end
    assign grpSig[g] = grpCtl_q[g][`AWDU_B_FILTER] ? filt_q[g] : grpRaw[g];
  end

  // routing: code n drives irq n, codes zero and two drive nothing
  wire [2:0] srcSig = {status_q, grpSig};
  wire [3:0] route [3];
  assign route[0] = grpCtl_q[0][7:4];
  assign route[1] = grpCtl_q[1][7:4];
  assign route[2] = reloadCfg_q[7:4];
  for (genvar n = 0; n < 16; n++)
  begin : g_irq
    for (genvar s = 0; s < 3; s++)
    begin : g_src
      assign routeHit[s][n] = srcSig[s] & (route[s] == 4'(n)) & (n != 0) & (n != 2);
    end
    assign irqOut[n] = routeHit[0][n] | routeHit[1][n] | routeHit[2][n];
  end

  // unit time base; the second prescaler also times the blink
  wire secTick  = (presc_q == PW'(CYCLES_PER_SEC - 1));
  wire minTick  = secTick & (minCnt_q == MW'(SEC_PER_MIN - 1));
  wire unitTick = unitSec_q ? secTick : minTick;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      presc_q  <= '0;
      minCnt_q <= '0;
    end
    else
    begin
      presc_q <= secTick ? '0 : presc_q + PW'(1);
      if (minTick)
        minCnt_q <= '0;
      else if (secTick)
        minCnt_q <= minCnt_q + MW'(1);
    end
  end

  // restart sources; keyboard and mouse irqs are levels, so only their rising edge counts
  wire kbdEdge   = keyboardIrq & ~kbdPrev_q;
  wire mouseEdge = mouseIrq & ~mousePrev_q;
  wire restart   = (reloadCfg_q[`AWDU_B_GAME] & gamePortAccess)
                 | (reloadCfg_q[`AWDU_B_KBD] & kbdEdge)
                 | (reloadCfg_q[`AWDU_B_MOUSE] & mouseEdge);
  wire running   = activate_q & (toVal_q != 8'h00) & (count_q != 8'h00);
  wire expire    = running & unitTick & (count_q == 8'h01) & ~restart & ~wrVal;

  always_comb
  begin
    count_d = count_q;
    if (wrVal)
      count_d = wb;
    else if (restart)
      count_d = toVal_q;
    else if (running && unitTick)
      count_d = count_q - 8'h01;
  end

  // status: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      count_q     <= 8'h00;
      status_q    <= 1'b0;
      kbdPrev_q   <= 1'b0;
      mousePrev_q <= 1'b0;
    end
    else
    begin
      count_q     <= count_d;
      kbdPrev_q   <= keyboardIrq;
      mousePrev_q <= mouseIrq;
      if (expire || forceWr)
        status_q <= 1'b1;
      else if (wrStat)
        status_q <= wb[`AWDU_B_STATUS];
    end
  end

  // blink on for the first half of each second while timed out
  wire blinkOn = (presc_q < PW'(CYCLES_PER_SEC / 2));
  wire blinking = status_q & reloadCfg_q[`AWDU_B_BLINK];
  assign powerIndicatorOutput = blinking ? blinkOn : powerLedIn;
  assign timeoutStatus = status_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_pin_input_off: assert property (pinCfg_q[0][0] |-> !padOe[0])
    else $error("input pin is driven");
  a_pin_polarity: assert property (!pinCfg_q[1][7] && !pinCfg_q[1][0] && pinCfg_q[1][4:3] == 2'h2
    |-> padOut[1] == (pinData_q[1] ^ pinCfg_q[1][1]))
    else $error("pin polarity wrong");
  a_pin_a_irq: assert property (!pinCfg_q[0][7] && pinCfg_q[0][4:3] == 2'h1
    |-> padOut[0] == (pinIrqLine[0] ^ pinCfg_q[0][1]))
    else $error("pin a irq function wrong");
  a_pin_b_data: assert property (!pinCfg_q[1][7] && pinCfg_q[1][4:3] == 2'h0
    |-> padOut[1] == (parallelDataLine[1] ^ pinCfg_q[1][1]))
    else $error("pin b data function wrong");
  a_group_member: assert property (!pinCfg_q[0][5] && !pinCfg_q[1][5] |-> !grpRaw[1])
    else $error("non member reached group two");
  a_pin_drain: assert property (pinCfg_q[0][7] |-> !padOut[0] && (padOe[0] -> !drvLvl[0]))
    else $error("open drain drives high");
  a_filter_bypass: assert property (!grpCtl_q[1][3] |-> grpSig[1] == grpRaw[1])
    else $error("bypassed filter delays group");
  a_irq_invalid: assert property (!irqOut[0] && !irqOut[2])
    else $error("invalid irq driven");
  a_grp_reserved: assert property (grpCtl_q[0][2:0] == 3'h0 && grpCtl_q[1][2:0] == 3'h0)
    else $error("group reserved bits set");
  a_minute_hold: assert property (!unitSec_q && secTick && !minTick && !restart && !wrVal |=> $stable(count_q))
    else $error("minute count moved on a second");
  a_zero_off: assert property (toVal_q == 8'h00 && !forceWr |=> !$rose(status_q))
    else $error("disabled watchdog expired");
  a_kbd_restart: assert property (reloadCfg_q[1] && kbdEdge && !wrVal |=> count_q == $past(toVal_q))
    else $error("keyboard restart missing");
  a_game_restart: assert property (reloadCfg_q[0] && gamePortAccess && !wrVal |=> count_q == $past(toVal_q))
    else $error("game port restart missing");
  a_mouse_ignore: assert property (!reloadCfg_q[2] && mouseEdge && !running && !wrVal
    && !(reloadCfg_q[1] && kbdEdge) && !(reloadCfg_q[0] && gamePortAccess) |=> $stable(count_q))
    else $error("ignored mouse restarted count");
  a_led_blink: assert property (blinking && blinkOn |-> powerIndicatorOutput)
    else $error("power indicator not blinking");
  a_expire_set: assert property (expire |=> status_q)
    else $error("timeout did not set status");
  a_value_reload: assert property (wrVal |=> count_q == $past(pwdata[7:0]))
    else $error("value write did not reload");

  // status, unit stepping, indicator and pin function paths the checks above leave open
  a_force_set: assert property (forceWr |=> status_q)
    else $error("forced timeout did not set status");
  a_status_clear: assert property (wrStat && !wb[`AWDU_B_STATUS] && !forceWr && !expire |=> !status_q)
    else $error("status clear ignored");
  a_second_step: assert property (unitSec_q && secTick && running && !restart && !wrVal
    |=> count_q == $past(count_q) - 8'h01)
    else $error("seconds count did not step");
  a_led_dark: assert property (blinking && !blinkOn |-> !powerIndicatorOutput)
    else $error("power indicator lit in off half");
  a_led_plain: assert property (!blinking |-> powerIndicatorOutput == powerLedIn)
    else $error("power indicator altered without blink");
  a_pin_a_data: assert property (!pinCfg_q[0][7] && pinCfg_q[0][4:3] == 2'h0
    |-> padOut[0] == (parallelDataLine[0] ^ pinCfg_q[0][1]))
    else $error("pin a data function wrong");
  a_reserved_float: assert property (pinCfg_q[1][4:3] == 2'h3 |-> !padOe[1])
    else $error("reserved function drives pin b");
endmodule

/* File: inc/awdu_params.svh */
// constants for the aux pin and watchdog unit: register indices, field positions, reset values, timing
// assumes a 125 MHz clock; register byte address is four times the index
`ifndef AWDU_PARAMS_SVH
`define AWDU_PARAMS_SVH
`define AWDU_IDX_PIN_A      8'hd6
`define AWDU_IDX_PIN_B      8'hd7
`define AWDU_IDX_GRP_TWO    8'hef
`define AWDU_IDX_GRP_ONE    8'hf0
`define AWDU_IDX_UNIT       8'hf1
`define AWDU_IDX_VALUE      8'hf2
`define AWDU_IDX_RELOAD     8'hf3
`define AWDU_IDX_STATUS     8'hf4
`define AWDU_IDX_PIN_DATA   8'hf5
`define AWDU_IDX_ACTIVATE   8'h30
`define AWDU_PIN_RESET      8'h01
`define AWDU_PIN_MASK       8'hbb
`define AWDU_GRP_MASK       8'hf8
`define AWDU_UNIT_MASK      8'h80
`define AWDU_ZERO_RESET     8'h00
`define AWDU_B_DIR          0
`define AWDU_B_POL          1
`define AWDU_B_MEMBER       5
`define AWDU_B_DRAIN        7
`define AWDU_B_FILTER       3
`define AWDU_B_SECONDS      7
`define AWDU_B_GAME         0
`define AWDU_B_KBD          1
`define AWDU_B_MOUSE        2
`define AWDU_B_BLINK        3
`define AWDU_B_STATUS       0
`define AWDU_B_FORCE        2
`define AWDU_CLK_NS         8
`define AWDU_SEC_NS         1000000000
`define AWDU_DEBOUNCE_NS    1000
`define AWDU_SEC_PER_MIN    60
`endif

/* File: inc/awdu_pkg.sv */
// types shared by the aux pin and watchdog unit
// assumes nothing of its surroundings
package awdu_pkg;
  typedef logic [7:0] awdu_byte_t;
  typedef logic [3:0] awdu_route_t;
  typedef enum logic [1:0]
  {
    AWDU_FN_DATA = 2'h0,
    AWDU_FN_IRQ  = 2'h1,
    AWDU_FN_GPIO = 2'h2,
    AWDU_FN_RSVD = 2'h3
  } awdu_func_e;
endpackage

/* File: tb/awdu_board_model.sv */
// board model: pads with pull-ups, outside pin drivers and host event sources
// assumes the bench asks for events one cycle at a time through kick
`timescale 1ns/10ps
module awdu_board_model (
  input  wire logic       clock,
  input  wire logic [1:0] padOut,
  input  wire logic [1:0] padOe,
  input  wire logic [1:0] extLevel,
  input  wire logic [1:0] extDrive,
  input  wire logic [2:0] kick,
  output logic      [1:0] padIn,
  output logic            gamePortAccess,
  output logic            keyboardIrq,
  output logic            mouseIrq
);
  // a pad released by both the unit and the outside driver floats up to the board pull-up, never to a stale value
  assign padIn = (padOe & padOut) | (~padOe & extDrive & extLevel) | (~padOe & ~extDrive);
  // one-cycle game access pulse, one-cycle keyboard and mouse interrupts
  always_ff @(posedge clock)
  begin
    gamePortAccess <= kick[0];
    keyboardIrq    <= kick[1];
    mouseIrq       <= kick[2];
  end
endmodule

/* File: tb/awdu_unit_test.sv */
// testbench for the aux pin and watchdog unit: apb tasks and directed sequences
// assumes the board model on the pads and short second, minute and debounce counts
`timescale 1ns/10ps
`include "awdu_params.svh"
module awdu_unit_test;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr, groupOneIn;
  logic        gamePortAccess, keyboardIrq, mouseIrq, powerLedIn, powerIndicatorOutput, timeoutStatus;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  padIn, padOut, padOe, dataLine, irqLine, extLevel, extDrive;
  logic [2:0]  kick;
  logic [15:0] irqOut;
  logic [7:0]  rdv;
  logic        err;
  int          n_mismatch, checked, k;
  localparam logic [7:0] IDX [7] = '{`AWDU_IDX_PIN_A, `AWDU_IDX_PIN_B, `AWDU_IDX_GRP_TWO, `AWDU_IDX_GRP_ONE,
                                     `AWDU_IDX_UNIT, `AWDU_IDX_VALUE, `AWDU_IDX_RELOAD};
  localparam logic [7:0] FULL [7] = '{8'hbb, 8'hbb, 8'hf8, 8'hf8, 8'h80, 8'hff, 8'hff};
  localparam logic [7:0] DEF [7] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] PC [7] = '{8'h10, 8'h12, 8'h90, 8'h92, 8'h00, 8'h08, 8'h18};
  localparam logic [1:0] PE [7] = '{2'b11, 2'b10, 2'b01, 2'b10, 2'b10, 2'b11, 2'b01};
  localparam logic [7:0] UN [2] = '{8'h80, 8'h7f};
  localparam int LO [2] = '{19, 59};
  localparam int HI [2] = '{45, 125};

  awdu_unit #(.CYCLES_PER_SEC(20), .SEC_PER_MIN(3), .DEBOUNCE_CYCLES(4)) awdu_unit_i (.clock(clock),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .parallelDataLine(dataLine), .pinIrqLine(irqLine), .groupOneIn(groupOneIn), .gamePortAccess(gamePortAccess),
    .keyboardIrq(keyboardIrq), .mouseIrq(mouseIrq), .powerLedIn(powerLedIn),
    .powerIndicatorOutput(powerIndicatorOutput), .timeoutStatus(timeoutStatus), .irqOut(irqOut));
  awdu_board_model awdu_board_model_i (.clock(clock), .padOut(padOut), .padOe(padOe), .extLevel(extLevel),
    .extDrive(extDrive), .kick(kick), .padIn(padIn), .gamePortAccess(gamePortAccess),
    .keyboardIrq(keyboardIrq), .mouseIrq(mouseIrq));

  // 125 MHz clock
  always #4 clock = ~clock;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; the request stands until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // let one edge pass so what this transfer wrote has settled before anyone looks at it
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk("register", {8'h0, exp}, {8'h0, rdv});
  endtask
  task automatic doReset();
    resetn <= 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
  endtask
  task automatic waitStatus(input int limit);
    k = 0;
    while (timeoutStatus !== 1'b1 && k < limit)
    begin
      @(posedge clock);
      k++;
    end
  endtask
  // kicks one restart source every ten cycles, twelve times
  task automatic kicks(input int s);
    repeat (12)
    begin
      kick <= 3'b001 << s;
      @(posedge clock);
      kick <= 3'b000;
      repeat (9) @(posedge clock);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // cut a hang short well beyond the expected run
  initial
  begin
    #(8 * 30000);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    {clock, resetn, psel, penable, pwrite, paddr, pwdata, groupOneIn, powerLedIn, kick} = '0;
    {extLevel, extDrive, dataLine} = '0;
    irqLine = 2'b11;
    n_mismatch = 0;
    checked = 0;
    doReset();
    for (int i = 0; i < 7; i++) rd(IDX[i], DEF[i]);
    for (int i = 0; i < 7; i++) apb(1'b1, IDX[i], 8'hff);
    for (int i = 0; i < 7; i++) rd(IDX[i], FULL[i]);
    apb(1'b0, 8'h77, 8'h00);
    chk("unmapped", 16'h0100, {7'h0, err, rdv});
    doReset();
    for (int i = 0; i < 7; i++) rd(IDX[i], DEF[i]);
    // output paths: data bits high, data lines low, irq lines high, pads pulled up
    apb(1'b1, `AWDU_IDX_PIN_DATA, 8'h03);
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 7; i++)
      begin
        apb(1'b1, IDX[p], PC[i]);
        chk("pad", {14'h0, PE[i]}, {14'h0, padOe[p], padIn[p]});
      end
    // input polarity seen through the pin data register; the board holds pin b low
    {extDrive, extLevel} <= 4'b1101;
    apb(1'b1, IDX[0], 8'h03);
    rd(`AWDU_IDX_PIN_DATA, 8'h03);
    apb(1'b1, IDX[0], 8'h01);
    rd(`AWDU_IDX_PIN_DATA, 8'h13);
    // grouped interrupt two: membership, invalid route, debounce
    apb(1'b1, IDX[2], 8'h50);
    chk("group off", 16'h0000, irqOut);
    apb(1'b1, IDX[0], 8'h21);
    chk("group on", 16'h0020, irqOut);
    apb(1'b1, IDX[2], 8'h20);
    chk("group invalid", 16'h0000, irqOut);
    apb(1'b1, IDX[2], 8'h58);
    repeat (10) @(posedge clock);
    extLevel <= 2'b00;
    repeat (2) @(posedge clock);
    chk("filter held", 16'h0020, irqOut);
    repeat (10) @(posedge clock);
    chk("filter passed", 16'h0000, irqOut);
    apb(1'b1, IDX[2], 8'h00);
    // grouped interrupt one over routing codes 1 to 15
    groupOneIn <= 1'b1;
    for (int r = 1; r < 16; r++)
    begin
      apb(1'b1, IDX[3], 8'(r << 4));
      chk("route", (r == 2) ? 16'h0 : 16'(1 << r), irqOut);
    end
    apb(1'b1, IDX[3], 8'h00);
    // timeout in seconds and in minutes, routed to irq 3, with blinking
    apb(1'b1, `AWDU_IDX_ACTIVATE, 8'h01);
    for (int u = 0; u < 2; u++)
    begin
      apb(1'b1, IDX[4], UN[u]);
      apb(1'b1, IDX[6], 8'h38);
      apb(1'b1, IDX[5], 8'h02);
      waitStatus(150);
      chk("wait span", 16'h1, 16'(k >= LO[u] && k <= HI[u]));
      chk("wdt irq", 16'h0008, irqOut);
      rd(`AWDU_IDX_STATUS, 8'h01);
      k = 0;
      repeat (20)
      begin
        @(posedge clock);
        k += int'(powerIndicatorOutput === 1'b1);
      end
      chk("blink", 16'd10, 16'(k));
      apb(1'b1, IDX[5], 8'h00);
      apb(1'b1, `AWDU_IDX_STATUS, 8'h00);
      chk("led plain", {15'h0, powerLedIn}, {15'h0, powerIndicatorOutput});
      chk("status clear", 16'h0000, {irqOut[15:1], timeoutStatus});
    end
    // each restart source keeps the timer alive only while enabled
    apb(1'b1, IDX[4], 8'h80);
    for (int s = 0; s < 3; s++)
    begin
      apb(1'b1, IDX[6], 8'(1 << s));
      apb(1'b1, IDX[5], 8'h02);
      kicks(s);
      chk("kept alive", 16'h0, {15'h0, timeoutStatus});
      apb(1'b1, IDX[6], 8'h00);
      kicks(s);
      chk("ignored", 16'h1, {15'h0, timeoutStatus});
      apb(1'b1, IDX[5], 8'h00);
      apb(1'b1, `AWDU_IDX_STATUS, 8'h00);
    end
    // software can force a timeout and clear it again
    apb(1'b1, `AWDU_IDX_STATUS, 8'h04);
    chk("forced", 16'h1, {15'h0, timeoutStatus});
    apb(1'b1, `AWDU_IDX_STATUS, 8'h00);
    chk("force clear", 16'h0, {15'h0, timeoutStatus});
    // a new value replaces the running count; zero stops it
    apb(1'b1, IDX[5], 8'h02);
    repeat (10) @(posedge clock);
    apb(1'b1, IDX[5], 8'h40);
    repeat (40) @(posedge clock);
    chk("reloaded", 16'h0, {15'h0, timeoutStatus});
    apb(1'b1, IDX[5], 8'h00);
    repeat (100) @(posedge clock);
    chk("stopped", 16'h0, {15'h0, timeoutStatus});
    apb(1'b1, `AWDU_IDX_ACTIVATE, 8'h00);
    apb(1'b1, IDX[5], 8'h01);
    repeat (60) @(posedge clock);
    chk("inactive", 16'h0, {15'h0, timeoutStatus});
    end_of_test();
  end
endmodule
